/* File: hdl/flash_decode_protect_power.sv */
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "flash_decode_defines.svh"
module flash_decode_protect_power
   import flash_decode_pkg::*;
#(
   parameter int SECT_ERASE_CYC = `FLASH_SECT_ERASE_US * `CLK_MHZ,
   parameter int ARR_ERASE_CYC  = `FLASH_ARR_ERASE_US * `CLK_MHZ
)
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        mcuRstN,
   output logic             resetFwd,
   input  wire logic        ale,
   input  wire logic [7:0]  addrHigh,
   input  wire logic [7:0]  adIn,
   output logic      [7:0]  adOut,
   output logic             adOe,
   input  wire logic        rdN,
   input  wire logic        wrN,
   input  wire logic        programFetchStrobeN,
   output logic      [7:0]  mainSectorSelect,
   output logic      [3:0]  secSectorSelect,
   output logic      [1:0]  flashBusy,
   output logic      [1:0]  flashStandby,
   input  wire logic [7:0]  plaIn,
   output logic      [7:0]  plaOut,
   output logic             plaSleep,
   output logic             powerDown,
   input  wire logic        jtagValid,
   input  wire logic [1:0]  jtagCmd,
   input  wire logic [7:0]  jtagAddr,
   input  wire logic [31:0] jtagWdata,
   output logic      [31:0] jtagRdata,
   output logic             jtagDenied,
   output logic             jtagDebugEn
);
   localparam int PROG_CYC = `FLASH_PROG_US * `CLK_MHZ;

   logic        rstAll, wrPrev_r, dataStrobe, fetchStrobe, activity;
   logic        csiopHit, wrStart, csWr, fcmdWr, sectProt, turbo;
   logic [7:0]  addrLow_r, usbBaseLow_r, pmmrA_r, pmmrC_r, csRdVal;
   logic [7:0]  macroRd, sectorIsProg_r, mainHit, gatedIn, gatedPrev_r;
   logic [3:0]  secHit;
   logic [11:0] prot_r, selFast_r, selSlow_r;
   logic [15:0] busAddr, apdLimit_r, apdCnt_r;
   logic [31:0] sectorBase_r, cfgData;
   logic [7:0]  cfgAddr;
   logic        secure_r, rstPolHigh_r, cfgWe, jtagWrOk, apbWr, apbErr;
   logic        respReady_r, protViolation_r, eraseAll_r, eraseClear;
   logic        refusedWr, macroHit, eraseReq;
   logic [1:0]  startProg, startSect, startArr, flashDone, eraseSeen_r;
   logic [1:0]  fop;

   assign rstAll   = rst | ~mcuRstN;
   assign resetFwd = rstPolHigh_r ? ~mcuRstN : mcuRstN;

   // multiplexed bus capture
   always_ff @(posedge clk_sys)
   begin
      if (rstAll)
      begin
         addrLow_r <= 8'h00;
         wrPrev_r  <= 1'b1;
      end
      else
      begin
         if (ale)
            addrLow_r <= adIn;
         wrPrev_r <= wrN;
      end
   end

   assign busAddr     = {addrHigh, addrLow_r};
   assign dataStrobe  = !rdN || !wrN;
   assign fetchStrobe = !programFetchStrobeN;
   assign activity    = ale || dataStrobe || fetchStrobe;
   assign csiopHit    = (addrHigh == `CSIOP_PAGE) && dataStrobe;
   assign wrStart     = !wrN && wrPrev_r;
   assign csWr        = wrStart && csiopHit;
   assign macroHit    = (addrLow_r[7:3] == `CS_MACRO_PAGE);

   // sector decode
   always_comb
   begin
      mainHit = 8'h00;
      secHit  = 4'h0;
      for (int i = 0; i < 8; i++)
         if (sectorBase_r[4*i +: 4] == busAddr[15:12])
            mainHit[i] = sectorIsProg_r[i] ? fetchStrobe : dataStrobe;
      if (csiopHit)
         mainHit = 8'h00;
      if (!csiopHit && (mainHit == 8'h00) && busAddr[15] && dataStrobe)
         secHit[busAddr[14:13]] = 1'b1;
   end

   // flash operation requests
   assign fcmdWr   = csWr && (addrLow_r == `CS_FLASH_CMD);
   assign eraseReq = jtagValid && jtagCmd == JT_ERASE && !eraseAll_r;
   assign fop      = adIn[7:6];
   assign sectProt = adIn[5] ? prot_r[8 + 32'(adIn[1:0])] :
                     prot_r[adIn[2:0]];
   assign refusedWr = wrStart &&
                      ((|(mainHit & prot_r[7:0])) ||
                       (|(secHit & prot_r[11:8])));
   always_comb
   begin
      startProg[0] = (wrStart && (|mainHit) && !refusedWr) ||
                     (cfgWe && cfgAddr == `APB_FLASH_PROG &&
                      !cfgData[`FPROG_ARR_BIT]);
      startProg[1] = (wrStart && (|secHit) && !refusedWr) ||
                     (cfgWe && cfgAddr == `APB_FLASH_PROG &&
                      cfgData[`FPROG_ARR_BIT]);
      startSect[0] = fcmdWr && fop == `FCMD_OP_SECT && !adIn[5] &&
                     !sectProt;
      startSect[1] = fcmdWr && fop == `FCMD_OP_SECT && adIn[5] &&
                     !sectProt;
      startArr[0]  = (fcmdWr && fop == `FCMD_OP_ARR && !adIn[5] &&
                      !(|prot_r[7:0])) || eraseReq;
      startArr[1]  = (fcmdWr && fop == `FCMD_OP_ARR && adIn[5] &&
                      !(|prot_r[11:8])) || eraseReq;
   end

   for (genvar g = 0; g < 2; g++)
   begin : gArr
      flash_array_ctrl #(
         .PROG_CYC (PROG_CYC),
         .SECT_CYC (SECT_ERASE_CYC),
         .ARR_CYC  (ARR_ERASE_CYC)
      ) uFlash (
         .clk_sys   (clk_sys),
         .rst       (rstAll),
         .startProg (startProg[g]),
         .startSect (startSect[g]),
         .startArr  (startArr[g]),
         .access    (g == 0 ? (|mainHit) : (|secHit)),
         .busy      (flashBusy[g]),
         .standby   (flashStandby[g]),
         .done      (flashDone[g])
      );
   end

   macrocell_store uMacro (
      .clk_sys (clk_sys),
      .rst     (rstAll),
      .we      (csWr && macroHit),
      .addr    (addrLow_r[2:0]),
      .wdata   (adIn),
      .rdata   (macroRd)
   );

   // processor side control registers
   always_ff @(posedge clk_sys)
   begin
      if (rstAll)
      begin
         usbBaseLow_r <= `USB_BASE_RST;
         pmmrA_r      <= `PMMR_RST;
         pmmrC_r      <= `PMMR_RST;
      end
      else if (csWr)
      begin
         if (addrLow_r == `CS_USB_BASE_LOW)
            usbBaseLow_r <= adIn & `USB_BASE_MASK;
         if (addrLow_r == `CS_PMMR_A)
            pmmrA_r <= adIn;
         if (addrLow_r == `CS_PMMR_C)
            pmmrC_r <= adIn;
      end
   end

   always_comb
   begin
      case (addrLow_r)
         `CS_PMMR_A:       csRdVal = pmmrA_r;
         `CS_PMMR_C:       csRdVal = pmmrC_r;
         `CS_PROT_MAIN:    csRdVal = prot_r[7:0];
         `CS_PROT_SEC:     csRdVal = {4'h0, prot_r[11:8]};
         `CS_USB_BASE_LOW: csRdVal = usbBaseLow_r;
         `CS_FLASH_CMD:    csRdVal = {6'h00, flashBusy};
         default:          csRdVal = macroHit ? macroRd : 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rstAll)
      begin
         adOut <= 8'h00;
         adOe  <= 1'b0;
      end
      else
      begin
         adOe <= !rdN && csiopHit;
         if (!rdN && csiopHit)
            adOut <= csRdVal;
      end
   end

   // decode outputs, one extra stage in turbo mode
   assign turbo = pmmrA_r[`TURBO_BIT];
   always_ff @(posedge clk_sys)
   begin
      if (rstAll)
      begin
         selFast_r <= 12'h000;
         selSlow_r <= 12'h000;
      end
      else
      begin
         selFast_r <= {secHit & {4{!flashBusy[1]}},
                       mainHit & {8{!flashBusy[0]}}};
         selSlow_r <= selFast_r;
      end
   end
   assign mainSectorSelect = turbo ? selSlow_r[7:0] : selFast_r[7:0];
   assign secSectorSelect  = turbo ? selSlow_r[11:8] : selFast_r[11:8];

   // logic array input gating and latching
   assign gatedIn = plaIn & ~{pmmrA_r[7:4], pmmrC_r[3:0]};
   always_ff @(posedge clk_sys)
   begin
      if (rstAll)
      begin
         gatedPrev_r <= 8'h00;
         plaOut      <= 8'h00;
         plaSleep    <= 1'b0;
      end
      else
      begin
         gatedPrev_r <= gatedIn;
         plaOut      <= turbo ? gatedPrev_r : gatedIn;
         plaSleep    <= turbo && (gatedPrev_r == plaOut);
      end
   end

   // automatic power-down
   always_ff @(posedge clk_sys)
   begin
      if (rstAll)
      begin
         apdCnt_r  <= 16'h0000;
         powerDown <= 1'b0;
      end
      else if (activity)
      begin
         apdCnt_r  <= 16'h0000;
         powerDown <= 1'b0;
      end
      else if (apdCnt_r >= apdLimit_r)
         powerDown <= pmmrA_r[`APD_EN_BIT];
      else
         apdCnt_r <= apdCnt_r + 16'h0001;
   end

   // configuration write path, jtag before apb
   assign jtagWrOk = jtagValid && jtagCmd == JT_WRITE && !secure_r;
   assign apbErr   = (paddr > `APB_STATUS) || (paddr[1:0] != 2'h0);
   assign pready   = respReady_r && !(jtagValid && jtagCmd == JT_WRITE);
   assign pslverr  = pready && apbErr;
   assign apbWr    = psel && penable && pwrite && pready && !apbErr;
   assign cfgWe    = jtagWrOk || apbWr;
   assign cfgAddr  = jtagWrOk ? jtagAddr : paddr;
   assign cfgData  = jtagWrOk ? jtagWdata : pwdata;
   assign eraseClear = eraseAll_r && ((eraseSeen_r | flashDone) == 2'h3);

   function automatic logic [31:0] readCfg(input logic [7:0] a);
      case (a)
         `APB_PROG_MAP: readCfg = {24'h0, sectorIsProg_r};
         `APB_PROT:     readCfg = {20'h0, prot_r};
         `APB_BASE:     readCfg = sectorBase_r;
         `APB_SECURE:   readCfg = {31'h0, secure_r};
         `APB_CTRL:     readCfg = {15'h0, rstPolHigh_r, apdLimit_r};
         `APB_STATUS:   readCfg = {16'h0, usbBaseLow_r, protViolation_r,
                                   eraseAll_r, powerDown, plaSleep,
                                   flashStandby, flashBusy};
         default:       readCfg = 32'h0000_0000;
      endcase
   endfunction

   always_ff @(posedge clk_sys)
   begin
      if (rstAll || eraseClear)
      begin
         sectorIsProg_r <= `PROG_MAP_RST;
         prot_r         <= `PROT_RST;
         sectorBase_r   <= `SECT_BASE_RST;
         secure_r       <= 1'b0;
         apdLimit_r     <= `APD_LIMIT_RST;
         rstPolHigh_r   <= 1'b0;
      end
      else if (cfgWe)
      begin
         case (cfgAddr)
            `APB_PROG_MAP: sectorIsProg_r <= cfgData[7:0];
            `APB_PROT:     prot_r <= cfgData[11:0];
            `APB_BASE:     sectorBase_r <= cfgData;
            `APB_SECURE:   secure_r <= secure_r | cfgData[0];
            `APB_CTRL:
            begin
               apdLimit_r   <= cfgData[15:0];
               rstPolHigh_r <= cfgData[`RST_POL_BIT];
            end
            default: ;
         endcase
      end
   end

   // apb answer timing and sticky refusal flag
   always_ff @(posedge clk_sys)
   begin
      if (rstAll)
      begin
         respReady_r     <= 1'b0;
         prdata          <= 32'h0000_0000;
         protViolation_r <= 1'b0;
      end
      else
      begin
         respReady_r <= psel && penable && !pready;
         if (psel && !pwrite)
            prdata <= apbErr ? 32'h0000_0000 : readCfg(paddr);
         if (refusedWr)
            protViolation_r <= 1'b1;
         else if (apbWr && paddr == `APB_STATUS && pwdata[7])
            protViolation_r <= 1'b0;
      end
   end

   // jtag port
   always_ff @(posedge clk_sys)
   begin
      if (rstAll)
      begin
         jtagRdata   <= 32'h0000_0000;
         jtagDenied  <= 1'b0;
         eraseAll_r  <= 1'b0;
         eraseSeen_r <= 2'h0;
      end
      else
      begin
         jtagDenied <= jtagValid && secure_r && jtagCmd != JT_ERASE;
         if (jtagValid && !secure_r && jtagCmd == JT_READ)
            jtagRdata <= readCfg(jtagAddr);
         if (eraseClear)
         begin
            eraseAll_r  <= 1'b0;
            eraseSeen_r <= 2'h0;
         end
         else if (jtagValid && jtagCmd == JT_ERASE && !eraseAll_r)
         begin
            eraseAll_r  <= 1'b1;
            eraseSeen_r <= 2'h0;
         end
         else if (eraseAll_r)
            eraseSeen_r <= eraseSeen_r | flashDone;
      end
   end
   assign jtagDebugEn = !secure_r;

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rstAll);

   sequence sEraseReq;
      jtagValid && jtagCmd == JT_ERASE && !eraseAll_r;
   endsequence
   sequence sEraseFinish;
      eraseAll_r && ((eraseSeen_r | flashDone) == 2'h3);
   endsequence

   chk_usb_low_write: assert property (
      csWr && addrLow_r == `CS_USB_BASE_LOW |=>
      usbBaseLow_r == {$past(adIn[7:6]), 6'h00})
      else $error("usb base low not stored as bits 7:6");
   chk_prot_refuse: assert property (
      refusedWr |-> !startProg[0] && !startProg[1] ##1 protViolation_r)
      else $error("protected sector write not refused");
   chk_sel_busy: assert property (
      flashBusy[0] && $past(flashBusy[0]) && $past(flashBusy[0], 2)
      |-> mainSectorSelect == 8'h00)
      else $error("busy array sector still selected");
   chk_standby_idle: assert property (
      !flashBusy[0] && !(|mainHit) |-> flashStandby[0])
      else $error("idle main array not in standby");
   chk_turbo_reset: assert property (
      $past(rstAll) |-> !turbo && mainSectorSelect == selFast_r[7:0])
      else $error("turbo bit not zero after reset");
   chk_sleep_hold: assert property (
      turbo && plaSleep && $stable(pmmrA_r) |=> $stable(plaOut))
      else $error("latched logic output changed while asleep");
   chk_apd_wake: assert property (
      activity |=> !powerDown && apdCnt_r == 16'h0000)
      else $error("power-down held during bus activity");
   chk_secure_deny: assert property (
      jtagValid && secure_r && jtagCmd != JT_ERASE |=>
      jtagDenied && $stable(sectorBase_r) && !jtagDebugEn)
      else $error("secured jtag request not denied");
   chk_erase_start: assert property (
      sEraseReq |=> eraseAll_r && (flashBusy == 2'b11 || $past(|flashBusy)))
      else $error("full erase did not start both arrays");
   chk_erase_unlock: assert property (
      sEraseFinish |=> !secure_r && !eraseAll_r && prot_r == `PROT_RST)
      else $error("full erase did not clear security");
   chk_gate_inputs: assert property (
      !turbo |=> plaOut == ($past(plaIn) &
                            ~$past({pmmrA_r[7:4], pmmrC_r[3:0]})))
      else $error("blocked input reached logic array");
endmodule

/* File: hdl/flash_decode_defines.svh */
`ifndef FLASH_DECODE_DEFINES_SVH
`define FLASH_DECODE_DEFINES_SVH
// clock and flash timing
`define CLK_MHZ              50
`define FLASH_PROG_US        20
`define FLASH_SECT_ERASE_US  1000
`define FLASH_ARR_ERASE_US   4000
// processor side control page and offsets
`define CSIOP_PAGE           8'h7F
`define CS_MACRO_PAGE        5'h04
`define CS_PMMR_A            8'hB0
`define CS_PMMR_C            8'hB4
`define CS_PROT_MAIN         8'hC0
`define CS_PROT_SEC          8'hC2
`define CS_FLASH_CMD         8'hF0
`define CS_USB_BASE_LOW      8'hF4
// field positions and values
`define TURBO_BIT            3
`define APD_EN_BIT           1
`define USB_BASE_MASK        8'hC0
`define USB_BASE_RST         8'h00
`define PMMR_RST             8'h00
`define FCMD_OP_SECT         2'h2
`define FCMD_OP_ARR          2'h3
`define FPROG_ARR_BIT        8
// software register byte offsets
`define APB_PROG_MAP         8'h00
`define APB_PROT             8'h04
`define APB_BASE             8'h08
`define APB_SECURE           8'h0C
`define APB_FLASH_PROG       8'h10
`define APB_CTRL             8'h14
`define APB_STATUS           8'h18
// software register reset values and reset polarity bit position
`define PROG_MAP_RST         8'hFF
`define PROT_RST             12'h000
`define SECT_BASE_RST        32'h7654_3210
`define APD_LIMIT_RST        16'h0100
`define RST_POL_BIT          16
`endif

/* File: hdl/flash_decode_pkg.sv */
package flash_decode_pkg;
   typedef enum logic [2:0] {
      FL_IDLE  = 3'b001,
      FL_PROG  = 3'b010,
      FL_ERASE = 3'b100
   } flash_state_t;
   typedef enum logic [1:0] {
      JT_WRITE = 2'h0,
      JT_READ  = 2'h1,
      JT_ERASE = 2'h2
   } jtag_cmd_t;
endpackage

/* File: hdl/flash_array_ctrl.sv */
`timescale 1ns/1ps
module flash_array_ctrl
   import flash_decode_pkg::*;
#(
   parameter int PROG_CYC = 16,
   parameter int SECT_CYC = 64,
   parameter int ARR_CYC  = 128
)
(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic startProg,
   input  wire logic startSect,
   input  wire logic startArr,
   input  wire logic access,
   output logic      busy,
   output logic      standby,
   output logic      done
);
   flash_state_t state_r;
   logic [31:0]  cnt_r;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_r <= FL_IDLE;
         cnt_r   <= 32'h0000_0000;
         done    <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (state_r)
            FL_IDLE:
            begin
               if (startArr)
               begin
                  state_r <= FL_ERASE;
                  cnt_r   <= 32'(ARR_CYC - 1);
               end
               else if (startSect)
               begin
                  state_r <= FL_ERASE;
                  cnt_r   <= 32'(SECT_CYC - 1);
               end
               else if (startProg)
               begin
                  state_r <= FL_PROG;
                  cnt_r   <= 32'(PROG_CYC - 1);
               end
            end
            FL_PROG, FL_ERASE:
            begin
               if (cnt_r == 32'h0000_0000)
               begin
                  state_r <= FL_IDLE;
                  done    <= 1'b1;
               end
               else
                  cnt_r <= cnt_r - 32'h0000_0001;
            end
            default: state_r <= FL_IDLE;
         endcase
      end
   end

   assign busy    = (state_r != FL_IDLE);
   assign standby = !busy && !access;
endmodule

/* File: hdl/macrocell_store.sv */
`timescale 1ns/1ps
module macrocell_store
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       we,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] cell_r [8];

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         for (int i = 0; i < 8; i++)
            cell_r[i] <= 8'h00;
         rdata <= 8'h00;
      end
      else
      begin
         if (we)
            cell_r[addr] <= wdata;
         rdata <= cell_r[addr];
      end
   end
endmodule

/* File: testbench/mcu_bus_model.sv */
`timescale 1ns/1ps
// processor side of the multiplexed bus, one access at a time
module mcu_bus_model
(
   input  wire logic       clk_sys,
   input  wire logic       slowBus,
   input  wire logic [7:0] adOut,
   output logic            ale,
   output logic      [7:0] addrHigh,
   output logic      [7:0] adIn,
   output logic            rdN,
   output logic            wrN,
   output logic            programFetchStrobeN
);
   initial
   begin
      ale = 1'b0;
      addrHigh = 8'h00;
      adIn = 8'hA5;
      rdN = 1'b1;
      wrN = 1'b1;
      programFetchStrobeN = 1'b1;
   end
   // kind 0 write, 1 read, 2 fetch; strobe stays low on return
   task automatic access(input int k, input logic [15:0] a,
                         input logic [7:0] d, output logic [7:0] r);
      @(posedge clk_sys);
      ale <= 1'b1;
      addrHigh <= a[15:8];
      adIn <= a[7:0];
      @(posedge clk_sys);
      ale <= 1'b0;
      @(posedge clk_sys);
      adIn <= (k == 0) ? d : ~a[7:0];
      wrN <= (k != 0);
      rdN <= (k != 1);
      programFetchStrobeN <= (k != 2);
      repeat (slowBus ? 4 : 3) @(posedge clk_sys);
      r = adOut;
   endtask
   // released bus shows the inverse of its last value
   task automatic finish_cycle();
      @(posedge clk_sys);
      rdN <= 1'b1;
      wrN <= 1'b1;
      programFetchStrobeN <= 1'b1;
      adIn <= ~adIn;
   endtask
endmodule

/* File: testbench/flash_decode_protect_power_tb.sv */
`timescale 1ns/1ps
`include "flash_decode_defines.svh"
`define CHK(a, b) \
   begin \
      comparisons++; \
      if ((a) !== (b)) \
      begin \
         numErrors++; \
         $display("ERROR %0t: got %h expected %h", $time, a, b); \
      end \
   end
module flash_decode_protect_power_tb
   import flash_decode_pkg::*;
;
   logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, e;
   logic        mcuRstN, resetFwd, ale, adOe, rdN, wrN, slowBus;
   logic        programFetchStrobeN, plaSleep, powerDown;
   logic        jtagValid, jtagDenied, jtagDebugEn;
   logic [1:0]  jtagCmd, flashBusy, flashStandby;
   logic [3:0]  secSectorSelect;
   logic [7:0]  paddr, addrHigh, adIn, adOut, mainSectorSelect, plaIn;
   logic [7:0]  plaOut, jtagAddr, r8, v;
   logic [7:0]  mc [8];
   logic [31:0] pwdata, prdata, jtagWdata, jtagRdata, r32;
   int          seed = 23914;
   int          numErrors = 0;
   int          comparisons = 0;
   int          n;

   flash_decode_protect_power #(.SECT_ERASE_CYC(20), .ARR_ERASE_CYC(60)) dut
   (
      .clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .mcuRstN, .resetFwd, .ale, .addrHigh, .adIn,
      .adOut, .adOe, .rdN, .wrN, .programFetchStrobeN, .mainSectorSelect,
      .secSectorSelect, .flashBusy, .flashStandby, .plaIn, .plaOut,
      .plaSleep, .powerDown, .jtagValid, .jtagCmd, .jtagAddr, .jtagWdata,
      .jtagRdata, .jtagDenied, .jtagDebugEn
   );
   mcu_bus_model mcu
   (
      .clk_sys, .slowBus, .adOut, .ale, .addrHigh, .adIn, .rdN, .wrN,
      .programFetchStrobeN
   );

   always #10 clk_sys = ~clk_sys;

   task automatic finish_test();
      $display("comparisons %0d errors %0d", comparisons, numErrors);
      if (numErrors == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic apb(input bit w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_sys);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
      begin
         numErrors++;
         $display("ERROR %0t: apb answer timed out", $time);
         finish_test();
      end
   endtask
   task automatic pc(input int k, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
      mcu.access(k, {`CSIOP_PAGE, a}, d, r);
      mcu.finish_cycle();
   endtask
   task automatic jtag(input jtag_cmd_t c, input logic [31:0] d);
      @(posedge clk_sys);
      jtagValid <= 1'b1;
      jtagCmd <= c;
      jtagAddr <= `APB_PROT;
      jtagWdata <= d;
      @(posedge clk_sys);
      jtagValid <= 1'b0;
      #1;
   endtask

   initial
   begin
      {clk_sys, psel, penable, pwrite, jtagValid, slowBus} = 6'h00;
      {rst, mcuRstN} = 2'b11;
      {paddr, jtagAddr, jtagCmd, pwdata, jtagWdata} = '0;
      plaIn = $random(seed);
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      apb(0, `APB_PROG_MAP, 0, r32);
      `CHK(r32[7:0], `PROG_MAP_RST)
      apb(0, `APB_STATUS, 0, r32);
      `CHK(r32[15:2], 14'h0003)
      apb(0, 8'h1C, 0, r32);
      `CHK(e, 1'b1)
      pc(1, `CS_PMMR_A, 0, r8);
      `CHK(r8[`TURBO_BIT], 1'b0)
      `CHK(resetFwd, mcuRstN)
      apb(1, `APB_CTRL, 32'h0001_0010, r32);
      @(negedge clk_sys);
      `CHK(resetFwd, ~mcuRstN)
      for (int i = 0; i < 4; i++)
      begin
         v = $random(seed);
         pc(0, `CS_USB_BASE_LOW, v, r8);
         pc(1, `CS_USB_BASE_LOW, 0, r8);
         `CHK(r8, v & `USB_BASE_MASK)
      end
      for (int i = 0; i < 8; i++)
      begin
         mc[i] = $random(seed);
         pc(0, 8'h20 + 8'(i), mc[i], r8);
      end
      for (int i = 0; i < 8; i++)
      begin
         pc(1, 8'h20 + 8'(i), 0, r8);
         `CHK({adOe, r8}, {1'b1, mc[i]})
      end
      jtag(JT_WRITE, 32'h5A3);
      jtag(JT_READ, 0);
      `CHK(jtagRdata[11:0], 12'h5A3)
      pc(0, `CS_PROT_MAIN, 8'h5C, r8);
      pc(1, `CS_PROT_MAIN, 0, r8);
      `CHK(r8, 8'hA3)
      pc(1, `CS_PROT_SEC, 0, r8);
      `CHK(r8, 8'h05)
      mcu.access(0, 16'h8000, 8'h3C, r8);
      mcu.finish_cycle();
      apb(0, `APB_STATUS, 0, r32);
      `CHK({flashBusy, r32[7]}, 3'b001)
      pc(0, `CS_FLASH_CMD, 8'h80, r8);
      pc(0, `CS_FLASH_CMD, 8'hC0, r8);
      `CHK(flashBusy, 2'b00)
      apb(1, `APB_PROT, 0, r32);
      pc(0, `CS_FLASH_CMD, 8'h83, r8);
      `CHK({flashBusy[0], flashStandby[0]}, 2'b10)
      for (n = 0; n < 99 && flashBusy !== 2'b00; n++) @(posedge clk_sys);
      `CHK(flashStandby, 2'b11)
      pc(0, `CS_FLASH_CMD, 8'hE0, r8);
      for (int t = 0; t < 2; t++)
      begin
         slowBus <= t[0];
         pc(0, `CS_PMMR_A, {4'h0, t[0], 3'h0}, r8);
         mcu.access(2, 16'h3000, 0, r8);
         `CHK({flashBusy[1], mainSectorSelect}, 9'h108)
         mcu.finish_cycle();
      end
      mcu.access(1, 16'h3000, 0, r8);
      `CHK(mainSectorSelect, 8'h00)
      mcu.finish_cycle();
      for (n = 0; n < 199 && flashBusy !== 2'b00; n++) @(posedge clk_sys);
      `CHK(flashBusy, 2'b00)
      slowBus <= 1'b0;
      pc(0, `CS_PMMR_A, 8'h02, r8);
      for (n = 0; n < 99 && powerDown !== 1'b1; n++) @(posedge clk_sys);
      `CHK(powerDown, 1'b1)
      pc(0, `CS_PMMR_C, 8'h0F, r8);
      plaIn <= $random(seed);
      repeat (2) @(posedge clk_sys);
      `CHK(plaOut, plaIn & 8'hF0)
      apb(1, `APB_PROT, 32'h0AB, r32);
      apb(1, `APB_SECURE, 1, r32);
      jtag(JT_READ, 0);
      `CHK({jtagDenied, jtagDebugEn}, 2'b10)
      jtag(JT_WRITE, 0);
      `CHK(jtagDenied, 1'b1)
      jtag(JT_ERASE, 0);
      for (n = 0; n < 400 && jtagDebugEn !== 1'b1; n++) @(posedge clk_sys);
      apb(0, `APB_PROT, 0, r32);
      `CHK({jtagDebugEn, r32[11:0]}, 13'h1000)
      finish_test();
   end
endmodule
